// ==== design/pcg_regs.svh ====
// Purpose: register offsets, field positions and reset values for the peripheral
//          clock gate and soft reset block
// Assumes: AHB-Lite word access, byte addresses as printed
// Notes:   offset, mask and reset value defines follow
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH
`define PCG_OFS_SRST0     12'h040
`define PCG_OFS_SRST1     12'h044
`define PCG_OFS_SRST2     12'h048
`define PCG_OFS_GATE_RUN  12'h108
`define PCG_OFS_GATE_SLP  12'h118
`define PCG_OFS_GATE_DSLP 12'h128
`define PCG_OFS_CTRL      12'h200
`define PCG_OFS_FSTAT     12'h204
`define PCG_OFS_FMASK     12'h208
`define PCG_OFS_FADDR     12'h20C
`define PCG_MASK_SRST0    32'h0000_0008
`define PCG_MASK_SRST1    32'h0303_0011
`define PCG_MASK_PORT     32'h0000_0007
`define PCG_RST_VAL       32'h0000_0000
`define PCG_CTRL_AUTO_BIT 0
`define PCG_NPERIPH       10
`endif

// ==== design/pcg_pkg.sv ====
// Purpose: types for the peripheral clock gate and soft reset block
// Assumes: nothing beyond the register header
// Notes:   peripheral index order is fixed by the pcg_vec_t comment
package pcg_pkg;
  // power states reported by the power manager
  typedef enum logic [1:0] {
    PCG_RUN   = 2'b00,
    PCG_SLEEP = 2'b01,
    PCG_DEEP  = 2'b10
  } pcg_pwr_e;
  // bus data phase bookkeeping
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
  } pcg_dphase_s;
  // per-peripheral enables: 0 port a, 1 port b, 2 port c, 3 watchdog, 4 uart,
  // 5 sync serial, 6 timer 0, 7 timer 1, 8 comparator 0, 9 comparator 1
  typedef logic [9:0] pcg_vec_t;
endpackage

// ==== design/pcg_fault_gen.sv ====
// Purpose: raises a bus fault for accesses to peripherals whose clock is off
// Assumes: selects come from the system bus decoder, same clock
// Notes:   output registered, one-cycle pulse per refused access
`include "pcg_regs.svh"
module pcg_fault_gen
  import pcg_pkg::*;
#(
  parameter int NP = `PCG_NPERIPH
) (
  // clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // selects and enables
  input  wire logic [NP-1:0] sel,
  input  wire logic [NP-1:0] clk_en,
  // fault pulse and index mask
  output logic               fault,
  output logic [NP-1:0]      fault_vec
);
  logic          fault_next;     // any refused access
  logic [NP-1:0] fault_vec_next; // which peripherals refused

  initial if (NP < 1) $error("pcg_fault_gen: NP must be positive");

  // an access to a gated-off peripheral is refused
  always_comb begin
    fault_vec_next = sel & ~clk_en;
    fault_next     = |fault_vec_next;
  end

  // register the result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault     <= 1'b0;
      fault_vec <= '0;
    end else begin
      fault     <= fault_next;
      fault_vec <= fault_vec_next;
    end
  end
endmodule

// ==== design/pcg_top.sv ====
// Purpose: peripheral clock gating and software reset with AHB-Lite registers
// Assumes: single clock hclk, async active-low hresetn, word accesses only
// Notes:   capability masks are inputs from the capability registers
`include "pcg_regs.svh"
module pcg_top
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // capability masks from the capability registers
  input  wire logic [31:0] capability_reg_1,
  input  wire logic [31:0] capability_reg_2,
  input  wire logic [31:0] capability_reg_4,
  // power state from the power manager, may be asynchronous
  input  wire logic [1:0]  pwr_state,
  // peripheral access selects from the system bus decoder
  input  wire pcg_vec_t    periph_sel,
  // per-peripheral clock enables and resets
  output pcg_vec_t         periph_clk_en,
  output pcg_vec_t         periph_rst,
  // bus fault and interrupt
  output logic             periph_bus_fault,
  output logic             irq
);
  // register state
  logic [31:0] srst0_reg, srst0_next;   // soft reset register 0
  logic [31:0] srst1_reg, srst1_next;   // soft reset register 1
  logic [31:0] srst2_reg, srst2_next;   // soft reset register 2
  logic [2:0]  gate_run_reg, gate_run_next;
  logic [2:0]  gate_slp_reg, gate_slp_next;
  logic [2:0]  gate_dslp_reg, gate_dslp_next;
  logic        auto_gating_select_reg, auto_gating_select_next;
  logic [9:0]  fstat_reg, fstat_next;   // sticky fault status
  logic [9:0]  fmask_reg, fmask_next;   // fault interrupt mask
  pcg_dphase_s dp_reg, dp_next;         // pending data phase
  logic [31:0] hrdata_next;
  logic        irq_next;
  pcg_vec_t    clk_en_next, rst_next;
  // power state synchroniser, first stage read only by the second
  logic [1:0]  pwr_s1_reg, pwr_s2_reg;
  logic        fault_w;
  pcg_vec_t    fault_vec_w;

  // word-masked write helper: only writable and capable bits change
  function automatic logic [31:0] mwrite(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] m);
    return (old & ~m) | (wd & m);
  endfunction

  // read-back mux for the mapped register words
  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    case (a)
      `PCG_OFS_SRST0:     rd_mux = srst0_reg;
      `PCG_OFS_SRST1:     rd_mux = srst1_reg;
      `PCG_OFS_SRST2:     rd_mux = srst2_reg;
      `PCG_OFS_GATE_RUN:  rd_mux = {29'h0, gate_run_reg};
      `PCG_OFS_GATE_SLP:  rd_mux = {29'h0, gate_slp_reg};
      `PCG_OFS_GATE_DSLP: rd_mux = {29'h0, gate_dslp_reg};
      `PCG_OFS_CTRL:      rd_mux = {31'h0, auto_gating_select_reg};
      `PCG_OFS_FSTAT:     rd_mux = {22'h0, fstat_reg};
      `PCG_OFS_FMASK:     rd_mux = {22'h0, fmask_reg};
      default:            rd_mux = `PCG_RST_VAL; // unmapped reads zero
    endcase
  endfunction

  // bus fault detection for gated peripherals
  pcg_fault_gen #(.NP(`PCG_NPERIPH)) u_fault (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .sel       (periph_sel),
    .clk_en    (periph_clk_en),
    .fault     (fault_w),
    .fault_vec (fault_vec_w)
  );

  // synchronise the power state, it comes from another domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_s1_reg <= PCG_RUN;
      pwr_s2_reg <= PCG_RUN;
    end else begin
      pwr_s1_reg <= pwr_state;
      pwr_s2_reg <= pwr_s1_reg;
    end
  end

  // next-state logic for registers, bus answer and peripheral controls
  always_comb begin
    logic        wr_ok;
    logic [2:0]  port_gate;
    wr_ok                   = dp_reg.wr;
    port_gate               = gate_run_reg;
    srst0_next              = srst0_reg;
    srst1_next              = srst1_reg;
    srst2_next              = srst2_reg;
    gate_run_next           = gate_run_reg;
    gate_slp_next           = gate_slp_reg;
    gate_dslp_next          = gate_dslp_reg;
    auto_gating_select_next = auto_gating_select_reg;
    fmask_next              = fmask_reg;
    fstat_next              = fstat_reg;
    dp_next                 = '0;
    hrdata_next             = `PCG_RST_VAL;
    // capture the address phase; zero-wait slave
    if (hsel && hready && htrans[1]) begin
      dp_next.wr   = hwrite;
      dp_next.rd   = !hwrite;
      dp_next.addr = haddr;
      if (!hwrite) hrdata_next = rd_mux(haddr);
    end
    // data phase writes
    if (wr_ok) begin
      case (dp_reg.addr)
        // masks combine writable bits with capability bits
        `PCG_OFS_SRST0: srst0_next = mwrite(srst0_reg, hwdata,
                                            `PCG_MASK_SRST0 & capability_reg_1);
        `PCG_OFS_SRST1: srst1_next = mwrite(srst1_reg, hwdata,
                                            `PCG_MASK_SRST1 & capability_reg_2);
        `PCG_OFS_SRST2: srst2_next = mwrite(srst2_reg, hwdata,
                                            `PCG_MASK_PORT & capability_reg_4);
        `PCG_OFS_GATE_RUN:  gate_run_next  = hwdata[2:0];
        `PCG_OFS_GATE_SLP:  gate_slp_next  = hwdata[2:0];
        `PCG_OFS_GATE_DSLP: gate_dslp_next = hwdata[2:0];
        `PCG_OFS_CTRL: auto_gating_select_next = hwdata[`PCG_CTRL_AUTO_BIT];
        `PCG_OFS_FMASK: fmask_next = hwdata[9:0];
        `PCG_OFS_FSTAT: fstat_next = fstat_reg & ~hwdata[9:0]; // write one clears
        default: ;
      endcase
    end
    // a fault in the clearing cycle still sets its bit
    fstat_next = fstat_next | fault_vec_w;
    // pick the gating set for the current power state
    if (auto_gating_select_reg) begin
      case (pwr_s2_reg)
        PCG_SLEEP: port_gate = gate_slp_reg;
        PCG_DEEP:  port_gate = gate_dslp_reg;
        default:   port_gate = gate_run_reg;
      endcase
    end
    // only the ports are gated here; other peripherals stay clocked
    clk_en_next = {7'h7F, port_gate};
    // soft resets drive peripheral resets while set
    rst_next = {srst1_reg[25], srst1_reg[24], srst1_reg[17], srst1_reg[16],
                srst1_reg[4], srst1_reg[0], srst0_reg[3], srst2_reg[2:0]};
    irq_next = |(fstat_reg & fmask_reg);
  end

  // registers; gates reset to zero so ports start unclocked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srst0_reg              <= `PCG_RST_VAL;
      srst1_reg              <= `PCG_RST_VAL;
      srst2_reg              <= `PCG_RST_VAL;
      gate_run_reg           <= 3'h0;
      gate_slp_reg           <= 3'h0;
      gate_dslp_reg          <= 3'h0;
      auto_gating_select_reg <= 1'b0;
      fstat_reg              <= 10'h000;
      fmask_reg              <= 10'h000;
      dp_reg                 <= '0;
      hrdata                 <= `PCG_RST_VAL;
      irq                    <= 1'b0;
      periph_clk_en          <= 10'h3F8; // ports off, the rest always clocked
      periph_rst             <= 10'h000;
    end else begin
      srst0_reg              <= srst0_next;
      srst1_reg              <= srst1_next;
      srst2_reg              <= srst2_next;
      gate_run_reg           <= gate_run_next;
      gate_slp_reg           <= gate_slp_next;
      gate_dslp_reg          <= gate_dslp_next;
      auto_gating_select_reg <= auto_gating_select_next;
      fstat_reg              <= fstat_next;
      fmask_reg              <= fmask_next;
      dp_reg                 <= dp_next;
      hrdata                 <= hrdata_next;
      irq                    <= irq_next;
      periph_clk_en          <= clk_en_next;
      periph_rst             <= rst_next;
    end
  end

  // zero-wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout        <= 1'b1;
      hresp            <= 1'b0;
      periph_bus_fault <= 1'b0;
    end else begin
      hreadyout        <= 1'b1;
      hresp            <= 1'b0;
      periph_bus_fault <= fault_w;
    end
  end

  // checks
  AST_GATE_RESET: assert property (@(posedge hclk) $rose(hresetn) |-> periph_clk_en[2:0] == 3'h0)
    else $error("port clocks not off after reset");
  AST_RUN_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    !auto_gating_select_reg |=> periph_clk_en[2:0] == $past(gate_run_reg))
    else $error("run set not applied");
  AST_SLEEP_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    auto_gating_select_reg && pwr_s2_reg == PCG_SLEEP |=> periph_clk_en[2:0] == $past(gate_slp_reg))
    else $error("sleep set not applied");
  AST_DEEP_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    auto_gating_select_reg && pwr_s2_reg == PCG_DEEP |=> periph_clk_en[2:0] == $past(gate_dslp_reg))
    else $error("deep set not applied");
  AST_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
    |(periph_sel & ~periph_clk_en) |-> ##2 periph_bus_fault)
    else $error("gated access not faulted");
  AST_SRST0_RO: assert property (@(posedge hclk) disable iff (!hresetn)
    (srst0_reg & ~`PCG_MASK_SRST0) == 32'h0000_0000) else $error("reset reg 0 spare bit");
  AST_SRST1_RO: assert property (@(posedge hclk) disable iff (!hresetn)
    (srst1_reg & ~`PCG_MASK_SRST1) == 32'h0000_0000) else $error("reset reg 1 spare bit");
  AST_SRST2_RO: assert property (@(posedge hclk) disable iff (!hresetn)
    (srst2_reg & ~`PCG_MASK_PORT) == 32'h0000_0000) else $error("reset reg 2 spare bit");
  AST_CAP_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_reg.wr && dp_reg.addr == `PCG_OFS_SRST1 && !capability_reg_2[0]
    |=> srst1_reg[0] == $past(srst1_reg[0])) else $error("capability mask ignored");
  AST_RST_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
    srst0_reg[3] |=> periph_rst[3]) else $error("watchdog reset not driven");
  AST_SLP_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_reg.wr && dp_reg.addr == `PCG_OFS_GATE_SLP |=> gate_slp_reg == $past(hwdata[2:0]))
    else $error("sleep gate write lost");
  AST_GATE_EN: assert property (@(posedge hclk) disable iff (!hresetn)
    $stable(auto_gating_select_reg) && !auto_gating_select_reg && gate_run_reg[0]
    |=> periph_clk_en[0]) else $error("enabled port not clocked");
  COV_SLEEP: cover property (@(posedge hclk) auto_gating_select_reg && pwr_s2_reg == PCG_SLEEP);
  COV_FAULT: cover property (@(posedge hclk) periph_bus_fault);
  COV_IRQ:   cover property (@(posedge hclk) irq);
endmodule

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for the peripheral clock gate and soft reset block
// Assumes: zero-wait slave, bus ready is fed back from hreadyout
// Notes:   read data is checked by a monitor against a queue of expected words
`include "pcg_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top import pcg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // implemented soft reset bits per register
  localparam logic [31:0] RST0_BITS = 32'h0000_0008;
  localparam logic [31:0] RST1_BITS = 32'h0303_0011;
  localparam logic [31:0] RST2_BITS = 32'h0000_0007;
  localparam logic [31:0] ONES      = 32'hFFFF_FFFF;
  // mapped words, all but ctrl and fault mask, that must read zero straight after reset
  localparam logic [11:0] RST_OFS [7] = '{`PCG_OFS_SRST0, `PCG_OFS_SRST1, `PCG_OFS_SRST2,
    `PCG_OFS_GATE_RUN, `PCG_OFS_GATE_SLP, `PCG_OFS_GATE_DSLP, `PCG_OFS_FSTAT};
  // bus and side-band signals
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, dp_rd;
  logic        periph_bus_fault, irq;
  logic [11:0] haddr;
  logic [1:0]  htrans, pwr_state;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, cap1, cap2, cap4;
  pcg_vec_t    periph_sel, periph_clk_en, periph_rst;
  // expected read words, oldest first
  logic [31:0] exp_q[$];
  int          bad_count, cmp_count, fault_cnt;
  // the one slave's ready closes the loop as the bus ready
  pcg_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .capability_reg_1(cap1), .capability_reg_2(cap2), .capability_reg_4(cap4),
    .pwr_state(pwr_state), .periph_sel(periph_sel), .periph_clk_en(periph_clk_en),
    .periph_rst(periph_rst), .periph_bus_fault(periph_bus_fault), .irq(irq));
  // 200 mhz clock
  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;
  // count fault pulses, each is one refused peripheral access
  always @(posedge hclk) begin
    if (periph_bus_fault === 1'b1) fault_cnt <= fault_cnt + 1;
  end
  // monitor: a read data phase ends here, so take the oldest note
  always @(posedge hclk) begin
    if (dp_rd) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[FAIL] %0t read without expectation", $time);
      end else begin
        `CHK(hrdata, exp_q.pop_front())
      end
    end
  end
  // verdict, the single place where the run ends
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // bounded wait for hready high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        $display("[FAIL] %0t bus hang", $time);
        report_and_stop();
      end
      @(posedge hclk);
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'b010;
    wait_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    dp_rd  <= ~w;
    wait_rdy();
    dp_rd  <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // bounded settle of the enable or reset vector, then compare
  task automatic chk_vec(input bit is_rst, input pcg_vec_t e);
    int n;
    for (n = 0; n < 10 && (is_rst ? periph_rst : periph_clk_en) !== e; n++) @(posedge hclk);
    `CHK(is_rst ? periph_rst : periph_clk_en, e)
  endtask
  // pulse one select; the fault lands two edges later, irq one more
  task automatic poke(input int b, input int nf);
    int f0;
    f0 = fault_cnt;
    @(posedge hclk);
    periph_sel <= pcg_vec_t'(1 << b);
    @(posedge hclk);
    periph_sel <= '0;
    repeat (6) @(posedge hclk);
    `CHK(fault_cnt, f0 + nf)
  endtask
  // peripheral reset order: ports a..c, watchdog, uart, ssi, timers, comparators
  function automatic pcg_vec_t rmap(input logic [31:0] r0, r1, r2);
    return {r1[25], r1[24], r1[17], r1[16], r1[4], r1[0], r0[3], r2[2:0]};
  endfunction
  initial begin
    logic [31:0] c1, c2, c4;
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; dp_rd = 1'b0; pwr_state = 2'b00; periph_sel = '0;
    cap1 = ONES; cap2 = ONES; cap4 = ONES; fault_cnt = 0;
    c1 = $urandom(32'h6672);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values of seven registers and of the enable and reset vectors
    foreach (RST_OFS[i]) rd(RST_OFS[i], '0);
    `CHK(periph_clk_en, 10'h3F8)
    `CHK(periph_rst, 10'h000)
    $display("test reset done");
    // all ones with full capability: only implemented bits stick
    wr(`PCG_OFS_SRST0, ONES);
    wr(`PCG_OFS_SRST1, ONES);
    wr(`PCG_OFS_SRST2, ONES);
    rd(`PCG_OFS_SRST0, RST0_BITS);
    rd(`PCG_OFS_SRST1, RST1_BITS);
    rd(`PCG_OFS_SRST2, RST2_BITS);
    chk_vec(1'b1, 10'h3FF);
    // random capabilities: bits not offered must ignore the clearing write
    for (int i = 0; i < 4; i++) begin
      c1 = $urandom;
      c2 = $urandom;
      c4 = $urandom;
      @(posedge hclk);
      cap1 <= c1; cap2 <= c2; cap4 <= c4;
      wr(`PCG_OFS_SRST0, '0);
      wr(`PCG_OFS_SRST1, '0);
      wr(`PCG_OFS_SRST2, '0);
      rd(`PCG_OFS_SRST0, RST0_BITS & ~c1);
      rd(`PCG_OFS_SRST1, RST1_BITS & ~c2);
      rd(`PCG_OFS_SRST2, RST2_BITS & ~c4);
      chk_vec(1'b1, rmap(RST0_BITS & ~c1, RST1_BITS & ~c2, RST2_BITS & ~c4));
      @(posedge hclk);
      cap1 <= ONES; cap2 <= ONES; cap4 <= ONES;
      wr(`PCG_OFS_SRST0, ONES);
      wr(`PCG_OFS_SRST1, ONES);
      wr(`PCG_OFS_SRST2, ONES);
    end
    wr(`PCG_OFS_SRST0, '0);
    wr(`PCG_OFS_SRST1, '0);
    wr(`PCG_OFS_SRST2, '0);
    chk_vec(1'b1, 10'h000);
    $display("test soft reset done");
    // distinct gate per set so the selected set is visible
    wr(`PCG_OFS_GATE_RUN, 32'hFFFF_FFF9);
    wr(`PCG_OFS_GATE_SLP, 32'hFFFF_FFFA);
    wr(`PCG_OFS_GATE_DSLP, 32'hFFFF_FFFC);
    rd(`PCG_OFS_GATE_SLP, 32'h0000_0002);
    rd(`PCG_OFS_GATE_DSLP, 32'h0000_0004);
    @(posedge hclk);
    pwr_state <= PCG_DEEP;
    repeat (8) @(posedge hclk);
    chk_vec(1'b0, 10'h3F9);
    wr(`PCG_OFS_CTRL, 32'h0000_0001);
    chk_vec(1'b0, 10'h3FC);
    @(posedge hclk);
    pwr_state <= PCG_SLEEP;
    chk_vec(1'b0, 10'h3FA);
    @(posedge hclk);
    pwr_state <= PCG_RUN;
    chk_vec(1'b0, 10'h3F9);
    wr(`PCG_OFS_GATE_DSLP, ONES);
    rd(`PCG_OFS_GATE_DSLP, 32'h0000_0007);
    wr(`PCG_OFS_CTRL, '0);
    $display("test gating done");
    // faults: port b unmasked, port a clocked, port c masked
    wr(`PCG_OFS_FMASK, 32'h0000_0002);
    poke(1, 1);
    `CHK(irq, 1'b1)
    rd(`PCG_OFS_FSTAT, 32'h0000_0002);
    wr(`PCG_OFS_FSTAT, 32'h0000_0002);
    repeat (3) @(posedge hclk);
    `CHK(irq, 1'b0)
    poke(0, 0);
    poke(2, 1);
    `CHK(irq, 1'b0)
    rd(`PCG_OFS_FSTAT, 32'h0000_0004);
    wr(`PCG_OFS_FSTAT, 32'h0000_0004);
    rd(`PCG_OFS_FSTAT, 32'h0000_0000);
    $display("test fault done");
    // unmapped word reads zero and ignores writes
    wr(`PCG_OFS_FADDR, ONES);
    rd(`PCG_OFS_FADDR, 32'h0000_0000);
    `CHK(hresp, 1'b0)
    $display("test unmapped done");
    repeat (2) @(posedge hclk);
    report_and_stop();
  end
endmodule
